// *** core/dcs_top.sv ***
// Control and status logic of an eight-channel audio DAC: mode capture,
// clock-ratio supervision, silence flags, analog mute and the write port.
// Assumes clock is the converter system clock; pins are asynchronous to it
// and the serial control port runs on its own shift clock.
`timescale 1ns/100ps
`default_nettype none
module dcs_top #(
  parameter int CNT_W = 16
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ctl_shift_clock,
  input wire logic ctl_select_n,
  input wire logic ctl_serial_in,
  input wire logic frame_clock,
  input wire logic bit_clock,
  input wire logic mute_in_n,
  input wire logic mode_pin_in,
  input wire logic mode_pin_open,
  input wire logic emphasis_select_pin,
  input wire logic format_select_pin,
  input wire logic [1:0] zero_group,
  input wire logic zero_invert,
  input wire logic word_len_32,
  input wire logic quad_rate,
  input wire logic zero_mute_enable,
  input wire logic dac_operation_enable,
  input wire logic dac_power_save,
  input wire logic reg_emphasis,
  input wire logic reg_tdm,
  input wire logic sample_strobe,
  input wire logic [7:0] sample_nonzero,
  output logic mode_i2c,
  output logic mode_parallel,
  output logic mode_spi,
  output logic emphasis_on,
  output logic tdm_format,
  output logic silence_flag_a,
  output logic silence_flag_b,
  output logic conversion_run,
  output logic analog_center,
  output logic dac_power_down,
  output logic mute_active_n_out,
  output logic mute_active_n_oe,
  output logic reg_write_strobe,
  output logic [6:0] reg_write_index,
  output logic [7:0] reg_write_data
);

  // Serial control port on the shift clock domain.
  logic spi_toggle;
  logic [6:0] spi_index;
  logic [7:0] spi_data;

  dcs_spi_rx #(
    .IDX_W(dcs_pkg::INDEX_W),
    .DAT_W(dcs_pkg::DATA_W)
  ) u_spi_rx (
    .ctl_shift_clock(ctl_shift_clock),
    .rst_b(rst_b),
    .ctl_select_n(ctl_select_n),
    .ctl_serial_in(ctl_serial_in),
    .word_toggle(spi_toggle),
    .word_index(spi_index),
    .word_data(spi_data)
  );

  // Two-flop synchronisers; index: 0 frame, 1 bit, 2 mute, 3 select, 4 mode level,
  // 5 mode open, 6 emphasis, 7 format, 8 control toggle.
  logic [8:0] meta;
  logic [8:0] sync;
  logic [8:0] prev;
  logic sel_rise_d;
  logic next_sel_rise_d;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      // Select starts at its idle high level so no false select rise follows reset.
      meta <= 9'h008;
      sync <= 9'h008;
      prev <= 9'h008;
      sel_rise_d <= 1'b0;
    end else begin
      meta <= {spi_toggle, format_select_pin, emphasis_select_pin, mode_pin_open,
               mode_pin_in, ctl_select_n, mute_in_n, bit_clock, frame_clock};
      sync <= meta;
      prev <= sync;
      sel_rise_d <= next_sel_rise_d;
    end
  end

  logic frame_rise;
  logic bck_rise;
  logic mute_in_low;
  logic tog_evt;
  assign frame_rise = sync[0] & ~prev[0];
  assign bck_rise = sync[1] & ~prev[1];
  assign mute_in_low = ~sync[2];
  assign next_sel_rise_d = sync[3] & ~prev[3];
  assign tog_evt = sync[8] ^ prev[8];

  // Mode capture, once per reset.
  logic [1:0] settle;
  logic mode_taken;
  dcs_pkg::dcs_mode_t mode;
  logic [1:0] next_settle;
  logic next_mode_taken;
  dcs_pkg::dcs_mode_t next_mode;

  always_comb begin
    next_settle = settle;
    next_mode_taken = mode_taken;
    next_mode = mode;
    if (!mode_taken) begin
      if (settle == dcs_pkg::MODE_SETTLE) begin
        next_mode_taken = 1'b1;
        if (sync[5]) begin
          next_mode = dcs_pkg::DCS_MODE_PAR;
        end else if (sync[4]) begin
          next_mode = dcs_pkg::DCS_MODE_SPI;
        end else begin
          next_mode = dcs_pkg::DCS_MODE_I2C;
        end
      end else begin
        next_settle = settle + 2'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      settle <= 2'h0;
      mode_taken <= 1'b0;
      mode <= dcs_pkg::DCS_MODE_I2C;
    end else begin
      settle <= next_settle;
      mode_taken <= next_mode_taken;
      mode <= next_mode;
    end
  end

  logic is_par;
  assign is_par = mode_taken & (mode == dcs_pkg::DCS_MODE_PAR);

  // Clock-ratio supervision: frame length in system clocks is compared with the
  // last frame, with a tolerance of two measured bit-clock periods. A halted
  // system clock simply freezes all of this, which holds every output.
  logic [CNT_W-1:0] bck_cnt;
  logic [CNT_W-1:0] bck_period;
  logic [CNT_W-1:0] frm_cnt;
  logic [CNT_W-1:0] frm_ref;
  logic ref_valid;
  logic [5:0] hold_cnt;
  dcs_pkg::dcs_sync_t sy_state;
  logic [CNT_W-1:0] next_bck_cnt;
  logic [CNT_W-1:0] next_bck_period;
  logic [CNT_W-1:0] next_frm_cnt;
  logic [CNT_W-1:0] next_frm_ref;
  logic next_ref_valid;
  logic [5:0] next_hold_cnt;
  dcs_pkg::dcs_sync_t next_sy_state;
  logic [CNT_W+1:0] tol;
  logic [CNT_W+1:0] meas;
  logic [CNT_W+1:0] ref_hi;
  logic [CNT_W+1:0] ref_lo;
  logic off_ratio;
  logic too_long;
  logic [5:0] hold_limit;

  always_comb begin
    tol = (CNT_W+2)'(bck_period) * (CNT_W+2)'(dcs_pkg::DRIFT_BCK);
    meas = (CNT_W+2)'(frm_cnt) + {{(CNT_W+1){1'b0}}, 1'b1};
    ref_hi = (CNT_W+2)'(frm_ref) + tol;
    ref_lo = ((CNT_W+2)'(frm_ref) > tol) ? (CNT_W+2)'(frm_ref) - tol : '0;
    off_ratio = (meas > ref_hi) | (meas < ref_lo);
    too_long = ref_valid & (meas > ref_hi);
    hold_limit = quad_rate ? dcs_pkg::HOLD_QUAD : dcs_pkg::HOLD_SINGLE;
    next_bck_cnt = (&bck_cnt) ? bck_cnt : bck_cnt + CNT_W'(1);
    next_bck_period = bck_period;
    if (bck_rise) begin
      next_bck_cnt = '0;
      next_bck_period = bck_cnt + CNT_W'(1);
    end
    next_frm_cnt = (&frm_cnt) ? frm_cnt : frm_cnt + CNT_W'(1);
    next_frm_ref = frm_ref;
    next_ref_valid = ref_valid;
    if (frame_rise) begin
      next_frm_cnt = '0;
      next_frm_ref = meas[CNT_W-1:0];
      next_ref_valid = 1'b1;
    end
    next_hold_cnt = hold_cnt;
    next_sy_state = sy_state;
    case (sy_state)
      dcs_pkg::DCS_SY_ACQUIRE: begin
        if (frame_rise && ref_valid && !off_ratio) begin
          next_sy_state = dcs_pkg::DCS_SY_HOLD;
          next_hold_cnt = 6'h00;
        end
      end
      dcs_pkg::DCS_SY_HOLD: begin
        if (too_long || (frame_rise && off_ratio)) begin
          next_sy_state = dcs_pkg::DCS_SY_ACQUIRE;
        end else if (frame_rise) begin
          next_hold_cnt = hold_cnt + 6'h01;
          if (hold_cnt + 6'h01 >= hold_limit) begin
            next_sy_state = dcs_pkg::DCS_SY_RUN;
          end
        end
      end
      dcs_pkg::DCS_SY_RUN: begin
        if (too_long || (frame_rise && off_ratio)) begin
          next_sy_state = dcs_pkg::DCS_SY_ACQUIRE;
        end
      end
      default: begin
        next_sy_state = dcs_pkg::DCS_SY_ACQUIRE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bck_cnt <= '0;
      bck_period <= '0;
      frm_cnt <= '0;
      frm_ref <= '0;
      ref_valid <= 1'b0;
      hold_cnt <= 6'h00;
      sy_state <= dcs_pkg::DCS_SY_ACQUIRE;
    end else begin
      bck_cnt <= next_bck_cnt;
      bck_period <= next_bck_period;
      frm_cnt <= next_frm_cnt;
      frm_ref <= next_frm_ref;
      ref_valid <= next_ref_valid;
      hold_cnt <= next_hold_cnt;
      sy_state <= next_sy_state;
    end
  end

  // Silence detection for the two flags.
  logic [10:0] zcnt [2];
  logic [1:0] zflag;
  logic [10:0] next_zcnt [2];
  logic [1:0] next_zflag;
  logic [7:0] zmask [2];

  always_comb begin
    case (is_par ? dcs_pkg::DCS_GRP_A : dcs_pkg::dcs_group_t'(zero_group))
      dcs_pkg::DCS_GRP_A: begin
        zmask[0] = dcs_pkg::CH_P1_LEFT;
        zmask[1] = dcs_pkg::CH_P1_RIGHT;
      end
      dcs_pkg::DCS_GRP_B: begin
        zmask[0] = dcs_pkg::CH_ALL;
        zmask[1] = dcs_pkg::CH_ALL;
      end
      dcs_pkg::DCS_GRP_C: begin
        zmask[0] = dcs_pkg::CH_P4;
        zmask[1] = dcs_pkg::CH_P1_3;
      end
      dcs_pkg::DCS_GRP_D: begin
        zmask[0] = dcs_pkg::CH_P1;
        zmask[1] = dcs_pkg::CH_P2_4;
      end
      default: begin
        zmask[0] = dcs_pkg::CH_P1_LEFT;
        zmask[1] = dcs_pkg::CH_P1_RIGHT;
      end
    endcase
    for (int f = 0; f < 2; f++) begin
      next_zcnt[f] = zcnt[f];
      next_zflag[f] = zflag[f];
      if (word_len_32) begin
        next_zcnt[f] = 11'h000;
        next_zflag[f] = 1'b0;
      end else if (sample_strobe && |(sample_nonzero & zmask[f])) begin
        next_zcnt[f] = 11'h000;
        next_zflag[f] = 1'b0;
      end else if (frame_rise && !zflag[f]) begin
        next_zcnt[f] = zcnt[f] + 11'h001;
        if (zcnt[f] + 11'h001 == dcs_pkg::ZERO_FRAMES) begin
          next_zflag[f] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      zcnt[0] <= 11'h000;
      zcnt[1] <= 11'h000;
      zflag <= 2'h0;
    end else begin
      zcnt[0] <= next_zcnt[0];
      zcnt[1] <= next_zcnt[1];
      zflag <= next_zflag;
    end
  end

  // Control writes: a word is held pending until the burst moves on or select
  // rises. Select is taken one cycle late so a toggle that crossed just ahead of
  // it is always seen first.
  logic pend_valid;
  logic [6:0] pend_index;
  logic [7:0] pend_data;
  logic next_pend_valid;
  logic [6:0] next_pend_index;
  logic [7:0] next_pend_data;
  logic next_wr_stb;
  logic [6:0] next_wr_idx;
  logic [7:0] next_wr_dat;

  always_comb begin
    next_pend_valid = pend_valid;
    next_pend_index = pend_index;
    next_pend_data = pend_data;
    next_wr_stb = 1'b0;
    next_wr_idx = reg_write_index;
    next_wr_dat = reg_write_data;
    if (tog_evt && mode_taken && mode == dcs_pkg::DCS_MODE_SPI) begin
      next_wr_stb = pend_valid;
      next_wr_idx = pend_index;
      next_wr_dat = pend_data;
      next_pend_valid = 1'b1;
      next_pend_index = spi_index;
      next_pend_data = spi_data;
    end else if (sel_rise_d && pend_valid) begin
      next_wr_stb = 1'b1;
      next_wr_idx = pend_index;
      next_wr_dat = pend_data;
      next_pend_valid = 1'b0;
    end
  end

  // Status and steering outputs, all registered.
  logic prog_mute;
  assign prog_mute = (sy_state != dcs_pkg::DCS_SY_RUN) | (zero_mute_enable & |zflag) | ~dac_operation_enable;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pend_valid <= 1'b0;
      pend_index <= 7'h00;
      pend_data <= 8'h00;
      reg_write_strobe <= 1'b0;
      reg_write_index <= 7'h00;
      reg_write_data <= 8'h00;
      mode_i2c <= 1'b0;
      mode_parallel <= 1'b0;
      mode_spi <= 1'b0;
      emphasis_on <= 1'b0;
      tdm_format <= 1'b0;
      silence_flag_a <= 1'b0;
      silence_flag_b <= 1'b0;
      conversion_run <= 1'b0;
      analog_center <= 1'b1;
      dac_power_down <= 1'b0;
      mute_active_n_out <= 1'b0;
      mute_active_n_oe <= 1'b1;
    end else begin
      pend_valid <= next_pend_valid;
      pend_index <= next_pend_index;
      pend_data <= next_pend_data;
      reg_write_strobe <= next_wr_stb;
      reg_write_index <= next_wr_idx;
      reg_write_data <= next_wr_dat;
      mode_i2c <= mode_taken & (mode == dcs_pkg::DCS_MODE_I2C);
      mode_parallel <= is_par;
      mode_spi <= mode_taken & (mode == dcs_pkg::DCS_MODE_SPI);
      emphasis_on <= is_par ? sync[6] : reg_emphasis;
      tdm_format <= is_par ? sync[7] : reg_tdm;
      silence_flag_a <= zflag[0] ^ (zero_invert & ~is_par);
      silence_flag_b <= zflag[1] ^ (zero_invert & ~is_par);
      conversion_run <= (sy_state == dcs_pkg::DCS_SY_RUN);
      analog_center <= mute_in_low | prog_mute;
      dac_power_down <= dac_power_save & ~mute_in_low;
      mute_active_n_out <= 1'b0;
      mute_active_n_oe <= prog_mute;
    end
  end

endmodule
`default_nettype wire

// *** core/dcs_pkg.sv ***
// Constants and types shared by the DAC control and status block.
// Assumes a single system clock domain plus the serial control shift clock.
package dcs_pkg;

  // Frames of muted hold-off after the clocks are back in step.
  localparam logic [5:0] HOLD_SINGLE = 6'h26;
  localparam logic [5:0] HOLD_QUAD = 6'h1D;

  // Allowed drift between frame and system clock, in bit-clock periods.
  localparam int unsigned DRIFT_BCK = 2;

  // All-zero frames before a silence flag rises.
  localparam logic [10:0] ZERO_FRAMES = 11'h400;

  // Serial control word layout.
  localparam int unsigned INDEX_W = 7;
  localparam int unsigned DATA_W = 8;
  localparam logic [4:0] WORD_LAST = 5'h0F;
  localparam logic [4:0] BURST_FIRST = 5'h10;
  localparam logic [4:0] BURST_LAST = 5'h17;

  // Clock edges after reset release before the mode pin is taken.
  localparam logic [1:0] MODE_SETTLE = 2'h2;

  // Channel masks: bit 2k is pair k+1 left, bit 2k+1 is pair k+1 right.
  localparam logic [7:0] CH_P1_LEFT = 8'h01;
  localparam logic [7:0] CH_P1_RIGHT = 8'h02;
  localparam logic [7:0] CH_ALL = 8'hFF;
  localparam logic [7:0] CH_P4 = 8'hC0;
  localparam logic [7:0] CH_P1_3 = 8'h3F;
  localparam logic [7:0] CH_P1 = 8'h03;
  localparam logic [7:0] CH_P2_4 = 8'hFC;

  typedef enum logic [1:0] {
    DCS_GRP_A = 2'h0,
    DCS_GRP_B = 2'h1,
    DCS_GRP_C = 2'h2,
    DCS_GRP_D = 2'h3
  } dcs_group_t;

  typedef enum logic [2:0] {
    DCS_MODE_I2C = 3'h1,
    DCS_MODE_PAR = 3'h2,
    DCS_MODE_SPI = 3'h4
  } dcs_mode_t;

  typedef enum logic [2:0] {
    DCS_SY_ACQUIRE = 3'h1,
    DCS_SY_HOLD = 3'h2,
    DCS_SY_RUN = 3'h4
  } dcs_sync_t;

endpackage

// *** core/dcs_spi_rx.sv ***
// Receiver of the three-wire control port, clocked by the shift clock only.
// Assumes the shift clock runs only while select is low; each finished write word
// or write burst byte is handed over by a toggle with stable index and data.
`timescale 1ns/100ps
`default_nettype none
module dcs_spi_rx #(
  parameter int IDX_W = 7,
  parameter int DAT_W = 8
) (
  input wire logic ctl_shift_clock,
  input wire logic rst_b,
  input wire logic ctl_select_n,
  input wire logic ctl_serial_in,
  output logic word_toggle,
  output logic [IDX_W-1:0] word_index,
  output logic [DAT_W-1:0] word_data
);

  // Select high clears the frame state without needing a shift clock edge.
  logic frame_rst_b;
  assign frame_rst_b = rst_b & ~ctl_select_n;

  logic [4:0] bit_cnt;
  logic [14:0] shreg;
  logic is_read;
  logic [IDX_W-1:0] cur_index;
  logic [4:0] next_bit_cnt;
  logic [14:0] next_shreg;
  logic next_is_read;
  logic [IDX_W-1:0] next_cur_index;
  logic emit;
  logic [IDX_W-1:0] emit_index;
  logic [DAT_W-1:0] emit_data;

  always_comb begin
    next_shreg = {shreg[13:0], ctl_serial_in};
    next_bit_cnt = bit_cnt + 5'h01;
    next_is_read = is_read;
    next_cur_index = cur_index;
    emit = 1'b0;
    emit_index = cur_index;
    emit_data = {shreg[6:0], ctl_serial_in};
    if (bit_cnt == 5'h00) begin
      next_is_read = ctl_serial_in;
    end
    if (bit_cnt == dcs_pkg::WORD_LAST) begin
      emit = ~is_read;
      emit_index = shreg[13:7];
      next_cur_index = shreg[13:7];
    end else if (bit_cnt == dcs_pkg::BURST_LAST) begin
      emit = ~is_read;
      emit_index = cur_index + 7'h01;
      next_cur_index = cur_index + 7'h01;
      next_bit_cnt = dcs_pkg::BURST_FIRST;
    end
  end

  always_ff @(posedge ctl_shift_clock or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      bit_cnt <= 5'h00;
      shreg <= 15'h0000;
      is_read <= 1'b0;
      cur_index <= 7'h00;
    end else begin
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      is_read <= next_is_read;
      cur_index <= next_cur_index;
    end
  end

  logic next_word_toggle;
  logic [IDX_W-1:0] next_word_index;
  logic [DAT_W-1:0] next_word_data;

  always_comb begin
    next_word_toggle = word_toggle;
    next_word_index = word_index;
    next_word_data = word_data;
    if (emit) begin
      next_word_toggle = ~word_toggle;
      next_word_index = emit_index;
      next_word_data = emit_data;
    end
  end

  // The hand-over state survives select so that a toggle is never undone.
  always_ff @(posedge ctl_shift_clock or negedge rst_b) begin
    if (!rst_b) begin
      word_toggle <= 1'b0;
      word_index <= 7'h00;
      word_data <= 8'h00;
    end else begin
      word_toggle <= next_word_toggle;
      word_index <= next_word_index;
      word_data <= next_word_data;
    end
  end

endmodule
`default_nettype wire

// *** test/dcs_top_props.sv ***
// Concurrent checks on the ports of the DAC control and status top.
// Assumes one system clock domain with an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module dcs_top_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic mute_in_n,
  input wire logic emphasis_select_pin,
  input wire logic zero_invert,
  input wire logic word_len_32,
  input wire logic dac_operation_enable,
  input wire logic mode_i2c,
  input wire logic mode_parallel,
  input wire logic mode_spi,
  input wire logic emphasis_on,
  input wire logic silence_flag_a,
  input wire logic silence_flag_b,
  input wire logic conversion_run,
  input wire logic analog_center,
  input wire logic dac_power_down,
  input wire logic mute_active_n_out,
  input wire logic mute_active_n_oe,
  input wire logic reg_write_strobe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  AST_MUTE_IN: assert property (!mute_in_n [*4] |=> analog_center && !dac_power_down)
    else $error("Mute input low did not center the outputs.");
  AST_DISABLE: assert property (!dac_operation_enable [*4] |=> mute_active_n_oe)
    else $error("DAC disable did not pull the mute status low.");
  AST_OD_LOW: assert property (!mute_active_n_out)
    else $error("Mute status pin drove a high level.");
  AST_DRIFT: assert property ($fell(conversion_run) |-> ##[0:3] analog_center)
    else $error("Loss of lock did not center the outputs.");
  AST_MODE_HOLD: assert property ((mode_i2c || mode_parallel || mode_spi)
    |=> $stable({mode_i2c, mode_parallel, mode_spi}))
    else $error("Captured mode changed without reset.");
  AST_PAR_EMPHASIS_SELECT_PIN: assert property (mode_parallel && $stable(emphasis_select_pin) [*4]
    |-> emphasis_on == emphasis_select_pin)
    else $error("Emphasis does not follow its pin in parallel mode.");
  AST_STB_SPI: assert property (reg_write_strobe |-> mode_spi)
    else $error("Register write outside three-wire mode.");
  AST_W32: assert property ((word_len_32 && !zero_invert) [*4] |=> !silence_flag_a && !silence_flag_b)
    else $error("Silence flag active with 32-bit samples.");
  cover property (reg_write_strobe);
  cover property ($rose(conversion_run));
  cover property ($rose(silence_flag_a));
endmodule
bind dcs_top dcs_top_checker u_chk (
  .clock, .rst_b, .mute_in_n, .emphasis_select_pin, .zero_invert, .word_len_32,
  .dac_operation_enable, .mode_i2c, .mode_parallel, .mode_spi, .emphasis_on,
  .silence_flag_a, .silence_flag_b, .conversion_run, .analog_center, .dac_power_down,
  .mute_active_n_out, .mute_active_n_oe, .reg_write_strobe
);
`default_nettype wire

// *** test/dcs_host_model.sv ***
// Host controller model driving the three-wire control port.
// Assumes the bench calls send through this instance, one frame at a time.
`timescale 1ns/100ps
`default_nettype none
module dcs_host_model #(
  parameter int HALF_NS = 60
) (
  output logic ctl_shift_clock,
  output logic ctl_select_n,
  output logic ctl_serial_in
);
  // A 15 ns link clock breaks the 100 ns minimum shift period, so each half spans four such periods.
  initial begin
    ctl_shift_clock = 1'b0;
    ctl_select_n = 1'b1;
    ctl_serial_in = 1'b0;
  end
  task automatic send(input logic [31:0] bits, input int n, input int slow);
    int i;
    ctl_select_n = 1'b0;
    #(HALF_NS * slow);
    for (i = n - 1; i >= 0; i--) begin
      ctl_serial_in = bits[i];
      #(HALF_NS * slow);
      ctl_shift_clock = 1'b1;
      #(HALF_NS * slow);
      ctl_shift_clock = 1'b0;
    end
    ctl_select_n = 1'b1;
    ctl_serial_in = ~ctl_serial_in;
    #(HALF_NS * slow * 2);
  endtask
endmodule
`default_nettype wire

// *** test/dac_control_and_status_test.sv ***
// Self-checking bench for the DAC control and status top.
// Assumes the host model drives the control port; audio clocks are ratiometric.
`timescale 1ns/100ps
`default_nettype none
module dac_control_and_status_test;
  logic clock = 1'b0, rst_b = 1'b0, frame_clock = 1'b0, bit_clock = 1'b0, mute_in_n = 1'b1;
  logic mode_pin_in = 1'b0, mode_pin_open = 1'b0, emphasis_select_pin = 1'b0, format_select_pin = 1'b0;
  logic zero_invert = 1'b0, word_len_32 = 1'b0, quad_rate = 1'b0, zero_mute_enable = 1'b0, reg_tdm = 1'b0;
  logic dac_operation_enable = 1'b1, dac_power_save = 1'b0, reg_emphasis = 1'b0, sample_strobe = 1'b0;
  logic [1:0] zero_group = 2'h0;
  logic [7:0] sample_nonzero = 8'h00;
  wire ctl_shift_clock, ctl_select_n, ctl_serial_in;
  logic mode_i2c, mode_parallel, mode_spi, emphasis_on, tdm_format, silence_flag_a, silence_flag_b;
  logic conversion_run, analog_center, dac_power_down, mute_active_n_out, mute_active_n_oe, reg_write_strobe;
  logic [6:0] reg_write_index;
  logic [7:0] reg_write_data;
  logic [14:0] wq[$];
  int n_mismatch = 0, n_tests = 0, fr_len = 30, fr_cnt = 0, bk_cnt = 0, k, q, m;
  always #2 clock = ~clock;
  // Audio clocks come from the system clock so the ratio never wanders by accident.
  always @(posedge clock) begin
    bk_cnt <= (bk_cnt == 5) ? 0 : bk_cnt + 1;
    fr_cnt <= (fr_cnt >= fr_len - 1) ? 0 : fr_cnt + 1;
    bit_clock <= #1 (bk_cnt < 3);
    frame_clock <= #1 (fr_cnt < 15);
  end
  always @(posedge clock) if (reg_write_strobe === 1'b1) wq.push_back({reg_write_index, reg_write_data});
  dcs_top dut (
    .clock, .rst_b, .ctl_shift_clock, .ctl_select_n, .ctl_serial_in, .frame_clock, .bit_clock,
    .mute_in_n, .mode_pin_in, .mode_pin_open, .emphasis_select_pin, .format_select_pin, .zero_group,
    .zero_invert, .word_len_32, .quad_rate, .zero_mute_enable, .dac_operation_enable, .dac_power_save,
    .reg_emphasis, .reg_tdm, .sample_strobe, .sample_nonzero, .mode_i2c, .mode_parallel, .mode_spi,
    .emphasis_on, .tdm_format, .silence_flag_a, .silence_flag_b, .conversion_run, .analog_center,
    .dac_power_down, .mute_active_n_out, .mute_active_n_oe, .reg_write_strobe, .reg_write_index,
    .reg_write_data
  );
  dcs_host_model host (.ctl_shift_clock, .ctl_select_n, .ctl_serial_in);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic frames(input int n);
    repeat (n) @(posedge frame_clock);
    tick(1);
  endtask
  task automatic do_reset(input logic lvl, input logic opn);
    rst_b = 1'b0;
    mode_pin_in = lvl;
    mode_pin_open = opn;
    tick(4);
    chk({analog_center, mute_active_n_oe, mode_i2c, mode_parallel, mode_spi, silence_flag_a, silence_flag_b}, 7'h60);
    rst_b = 1'b1;
    tick(6);
  endtask
  task automatic strobe(input logic [7:0] nz);
    sample_nonzero = nz;
    sample_strobe = 1'b1;
    tick(1);
    sample_strobe = 1'b0;
    tick(4);
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #380000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    for (m = 0; m < 3; m++) begin
      do_reset(m == 1, m == 2);
      chk({mode_i2c, mode_parallel, mode_spi}, m == 0 ? 3'h4 : m == 1 ? 3'h1 : 3'h2);
      host.send({1'b0, 7'h12, 8'hA5}, 16, 1);
      tick(10);
      chk(wq.size(), m == 1);
      if (m == 1) chk(wq.pop_front(), {7'h12, 8'hA5});
      wq.delete();
    end
    zero_invert = 1'b1;
    reg_tdm = 1'b1;
    for (k = 0; k < 4; k++) begin
      emphasis_select_pin = k[0];
      format_select_pin = k[1];
      tick(5);
      chk({emphasis_on, tdm_format, silence_flag_a, silence_flag_b}, {k[0], k[1], 2'b00});
    end
    zero_invert = 1'b0;
    mode_pin_open = 1'b0;
    mode_pin_in = 1'b1;
    tick(8);
    chk({mode_parallel, mode_spi}, 2'h2);
    do_reset(1'b1, 1'b0);
    word_len_32 = 1'b1;
    reg_emphasis = 1'b1;
    reg_tdm = 1'b0;
    emphasis_select_pin = 1'b0;
    host.send({1'b1, 7'h12, 8'hA5}, 16, 1);
    host.send({1'b0, 7'h12, 8'hA5}, 15, 1);
    host.send({1'b0, 7'h7F, 8'h11, 8'h22, 8'h33}, 32, 2);
    tick(10);
    chk(wq.size(), 3);
    chk(wq[0], {7'h7F, 8'h11});
    chk(wq[1], {7'h00, 8'h22});
    chk(wq[2], {7'h01, 8'h33});
    chk({emphasis_on, tdm_format}, 2'h2);
    k = 0;
    while (conversion_run !== 1'b1 && k < 3000) begin
      tick(1);
      k++;
    end
    chk({conversion_run, analog_center, mute_active_n_oe}, 3'h4);
    dac_operation_enable = 1'b0;
    tick(6);
    chk({analog_center, mute_active_n_oe}, 2'h3);
    dac_operation_enable = 1'b1;
    mute_in_n = 1'b0;
    dac_power_save = 1'b1;
    tick(6);
    chk({analog_center, dac_power_down, mute_active_n_oe}, 3'h4);
    mute_in_n = 1'b1;
    tick(6);
    chk({analog_center, dac_power_down}, 2'h1);
    dac_power_save = 1'b0;
    for (q = 0; q < 2; q++) begin
      quad_rate = q[0];
      fr_len = 36;
      frames(1);
      fr_len = 30;
      frames(2);
      chk({conversion_run, analog_center}, 2'h2);
      fr_len = 54;
      frames(1);
      fr_len = 30;
      chk({conversion_run, analog_center, mute_active_n_oe}, 3'h3);
      k = 0;
      while (conversion_run !== 1'b1 && k < 60) begin
        frames(1);
        k++;
      end
      chk(k >= (q ? 29 : 38) && k <= (q ? 33 : 42), 1'b1);
    end
    frames(1030);
    chk({silence_flag_a, silence_flag_b}, 2'h0);
    word_len_32 = 1'b0;
    zero_group = 2'h2;
    strobe(8'hFF);
    frames(1020);
    chk({silence_flag_a, silence_flag_b}, 2'h0);
    frames(6);
    chk({silence_flag_a, silence_flag_b}, 2'h3);
    zero_mute_enable = 1'b1;
    tick(6);
    chk(mute_active_n_oe, 1'b1);
    zero_mute_enable = 1'b0;
    zero_invert = 1'b1;
    tick(6);
    chk({silence_flag_a, silence_flag_b, mute_active_n_oe}, 3'h0);
    zero_invert = 1'b0;
    strobe(8'h04);
    chk({silence_flag_a, silence_flag_b}, 2'h2);
    zero_group = 2'h3;
    strobe(8'h40);
    chk({silence_flag_a, silence_flag_b}, 2'h2);
    zero_group = 2'h1;
    strobe(8'h08);
    chk({silence_flag_a, silence_flag_b}, 2'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
